/* File: char_lcd_access_bridge.sv */
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module char_lcd_access_bridge
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic lcd_rs,
  output logic lcd_rw,
  output logic lcd_en,
  input wire logic [7:0] lcd_d_in,
  output logic [7:0] lcd_d_out,
  output logic lcd_d_oe,
  output logic secondary_irq_input_seven
);
  logic aw_held;
  logic next_aw_held;
  logic [31:0] aw_addr;
  logic [31:0] next_aw_addr;
  logic w_held;
  logic next_w_held;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic [3:0] w_strb;
  logic [3:0] next_w_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [1:0] next_rresp;
  logic [31:0] next_rdata;
  logic deferred_access_done;
  logic next_done_flag;
  logic irq_mask;
  logic next_irq_mask;
  logic next_irq;
  logic pending;
  logic next_pending;
  logic pend_data;
  logic next_pend_data;
  logic pend_read;
  logic next_pend_read;
  logic [7:0] pend_byte;
  logic [7:0] next_pend_byte;
  logic seq_busy;
  logic seq_done;
  logic [7:0] seq_rdata;
  logic seq_start;
  logic do_write;
  logic do_read;
  logic wr_port;
  logic rd_port;
  logic wr_ok;
  logic rd_ok;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign do_read = s_axi_arvalid & s_axi_arready;
  assign wr_port = (aw_addr == char_lcd_pkg::COMMAND_PORT_ADDR)
    | (aw_addr == char_lcd_pkg::DATA_PORT_ADDR);
  assign rd_port = (s_axi_araddr == char_lcd_pkg::COMMAND_PORT_ADDR)
    | (s_axi_araddr == char_lcd_pkg::DATA_PORT_ADDR);
  assign seq_start = pending & ~seq_busy;

  lcd_access_sequencer u_seq
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(seq_start),
    .sel_data(pend_data),
    .is_read(pend_read),
    .wdata(pend_byte),
    .busy(seq_busy),
    .done(seq_done),
    .rdata(seq_rdata),
    .lcd_rs(lcd_rs),
    .lcd_rw(lcd_rw),
    .lcd_en(lcd_en),
    .lcd_d_in(lcd_d_in),
    .lcd_d_out(lcd_d_out),
    .lcd_d_oe(lcd_d_oe)
  );

  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    next_done_flag = deferred_access_done;
    next_irq_mask = irq_mask;
    next_pending = pending;
    next_pend_data = pend_data;
    next_pend_read = pend_read;
    next_pend_byte = pend_byte;
    wr_ok = 1'b0;
    rd_ok = 1'b0;
    if (s_axi_awvalid & s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid & s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid & s_axi_bready)
      next_bvalid = 1'b0;
    if (s_axi_rvalid & s_axi_rready)
      next_rvalid = 1'b0;
    if (seq_start)
      next_pending = 1'b0;
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      wr_ok = 1'b1;
      case (aw_addr)
        char_lcd_pkg::COMMAND_PORT_ADDR,
        char_lcd_pkg::DATA_PORT_ADDR:
        begin
          // A request while one is still queued is dropped
          if (w_strb[0] & ~pending)
          begin
            next_pending = 1'b1;
            next_pend_data =
              (aw_addr == char_lcd_pkg::DATA_PORT_ADDR);
            next_pend_read = 1'b0;
            next_pend_byte = w_data[7:0];
          end
        end
        char_lcd_pkg::RAW_FLAG_ADDR:
          if (w_strb[0] & ~w_data[char_lcd_pkg::FLAG_BIT])
            next_done_flag = 1'b0;
        char_lcd_pkg::IRQ_MASK_ADDR:
          if (w_strb[0])
            next_irq_mask = w_data[char_lcd_pkg::FLAG_BIT];
        char_lcd_pkg::CAPTURED_BYTE_ADDR,
        char_lcd_pkg::MASKED_STATUS_ADDR:
          wr_ok = 1'b1;
        default:
          wr_ok = 1'b0;
      endcase
      next_bresp = wr_ok ? char_lcd_pkg::RESP_OKAY
        : char_lcd_pkg::RESP_SLVERR;
    end
    if (do_read)
    begin
      next_rvalid = 1'b1;
      next_rdata = 32'h0000_0000;
      rd_ok = 1'b1;
      case (s_axi_araddr)
        char_lcd_pkg::COMMAND_PORT_ADDR,
        char_lcd_pkg::DATA_PORT_ADDR:
        begin
          // Returned word is not module data; result lands in capture reg
          if (~pending)
          begin
            next_pending = 1'b1;
            next_pend_data = (s_axi_araddr
              == char_lcd_pkg::DATA_PORT_ADDR);
            next_pend_read = 1'b1;
          end
        end
        char_lcd_pkg::CAPTURED_BYTE_ADDR:
          next_rdata[7:0] = seq_rdata;
        char_lcd_pkg::RAW_FLAG_ADDR:
          next_rdata[char_lcd_pkg::FLAG_BIT] = deferred_access_done;
        char_lcd_pkg::IRQ_MASK_ADDR:
          next_rdata[char_lcd_pkg::FLAG_BIT] = irq_mask;
        char_lcd_pkg::MASKED_STATUS_ADDR:
          next_rdata[char_lcd_pkg::FLAG_BIT] =
            deferred_access_done & irq_mask;
        default:
          rd_ok = 1'b0;
      endcase
      next_rresp = rd_ok ? char_lcd_pkg::RESP_OKAY
        : char_lcd_pkg::RESP_SLVERR;
    end
    // New access clears the stale flag; completion set wins over clears
    if ((do_write & wr_port & ~pending & w_strb[0])
      | (do_read & rd_port & ~pending))
      next_done_flag = 1'b0;
    if (seq_done)
      next_done_flag = 1'b1;
  end

  // Built from next values so the line rises with the flag, not a cycle late
  always_comb
  begin
    next_irq = next_done_flag & next_irq_mask;
  end

  // Write channel: address and data are held until both have arrived
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else
    begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
    end
    else
    begin
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      deferred_access_done <= 1'b0;
      irq_mask <= 1'b0;
      secondary_irq_input_seven <= 1'b0;
    end
    else
    begin
      deferred_access_done <= next_done_flag;
      irq_mask <= next_irq_mask;
      secondary_irq_input_seven <= next_irq;
    end
  end

  // Single slot: the slow module cannot keep up with a deeper queue anyway
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pending <= 1'b0;
      pend_data <= 1'b0;
      pend_read <= 1'b0;
      pend_byte <= 8'h00;
    end
    else
    begin
      pending <= next_pending;
      pend_data <= next_pend_data;
      pend_read <= next_pend_read;
      pend_byte <= next_pend_byte;
    end
  end
endmodule

/* File: char_lcd_pkg.sv */
package char_lcd_pkg;
  localparam int ADDR_W = 32;
  localparam logic [31:0] BASE_ADDR = 32'h1000_8000;
  localparam logic [31:0] COMMAND_PORT_ADDR = 32'h1000_8000;
  localparam logic [31:0] DATA_PORT_ADDR = 32'h1000_8004;
  localparam logic [31:0] CAPTURED_BYTE_ADDR = 32'h1000_8008;
  localparam logic [31:0] RAW_FLAG_ADDR = 32'h1000_800C;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'h1000_8010;
  localparam logic [31:0] MASKED_STATUS_ADDR = 32'h1000_8014;
  localparam int FLAG_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_PERIOD_NS = 25;
  localparam int ACCESS_TIME_NS = 500;
  // Least time: round up
  localparam int ACCESS_CYCLES =
    (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYCLES = ACCESS_CYCLES / 4;
  localparam int PULSE_CYCLES = ACCESS_CYCLES / 2;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_SETUP_END = CNT_W'(SETUP_CYCLES);
  localparam logic [CNT_W-1:0] CNT_PULSE_END =
    CNT_W'(SETUP_CYCLES + PULSE_CYCLES);
  localparam logic [CNT_W-1:0] CNT_DONE_END = CNT_W'(ACCESS_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  typedef enum {LCD_IDLE, LCD_SETUP, LCD_PULSE, LCD_HOLD} lcd_state_e;
endpackage

/* File: lcd_access_sequencer.sv */
`timescale 1ns/10ps
module lcd_access_sequencer
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic sel_data,
  input wire logic is_read,
  input wire logic [7:0] wdata,
  output logic busy,
  output logic done,
  output logic [7:0] rdata,
  output logic lcd_rs,
  output logic lcd_rw,
  output logic lcd_en,
  input wire logic [7:0] lcd_d_in,
  output logic [7:0] lcd_d_out,
  output logic lcd_d_oe
);
  char_lcd_pkg::lcd_state_e state;
  char_lcd_pkg::lcd_state_e next_state;
  logic [char_lcd_pkg::CNT_W-1:0] cnt;
  logic [char_lcd_pkg::CNT_W-1:0] next_cnt;
  logic next_rs;
  logic next_rw;
  logic next_en;
  logic [7:0] next_dout;
  logic next_oe;
  logic [7:0] next_rdata;
  logic next_done;

  assign busy = (state != char_lcd_pkg::LCD_IDLE);

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_rs = lcd_rs;
    next_rw = lcd_rw;
    next_en = 1'b0;
    next_dout = lcd_d_out;
    next_oe = lcd_d_oe;
    next_rdata = rdata;
    next_done = 1'b0;
    case (state)
      char_lcd_pkg::LCD_IDLE:
      begin
        next_cnt = char_lcd_pkg::CNT_ZERO;
        if (start)
        begin
          next_state = char_lcd_pkg::LCD_SETUP;
          next_rs = sel_data;
          next_rw = is_read;
          next_dout = wdata;
          next_oe = ~is_read;
        end
      end
      char_lcd_pkg::LCD_SETUP:
      begin
        next_cnt = cnt + char_lcd_pkg::CNT_ONE;
        if (cnt == char_lcd_pkg::CNT_SETUP_END)
        begin
          next_state = char_lcd_pkg::LCD_PULSE;
          next_en = 1'b1;
        end
      end
      char_lcd_pkg::LCD_PULSE:
      begin
        next_cnt = cnt + char_lcd_pkg::CNT_ONE;
        next_en = 1'b1;
        if (cnt == char_lcd_pkg::CNT_PULSE_END)
        begin
          // Sample before the falling enable edge
          next_en = 1'b0;
          if (lcd_rw)
            next_rdata = lcd_d_in;
          next_state = char_lcd_pkg::LCD_HOLD;
        end
      end
      char_lcd_pkg::LCD_HOLD:
      begin
        next_cnt = cnt + char_lcd_pkg::CNT_ONE;
        if (cnt == char_lcd_pkg::CNT_DONE_END)
        begin
          next_state = char_lcd_pkg::LCD_IDLE;
          next_done = 1'b1;
          next_oe = 1'b0;
        end
      end
      default:
        next_state = char_lcd_pkg::LCD_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= char_lcd_pkg::LCD_IDLE;
      cnt <= char_lcd_pkg::CNT_ZERO;
      lcd_rs <= 1'b0;
      lcd_rw <= 1'b0;
      lcd_en <= 1'b0;
      lcd_d_out <= 8'h00;
      lcd_d_oe <= 1'b0;
      rdata <= 8'h00;
      done <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      lcd_rs <= next_rs;
      lcd_rw <= next_rw;
      lcd_en <= next_en;
      lcd_d_out <= next_dout;
      lcd_d_oe <= next_oe;
      rdata <= next_rdata;
      done <= next_done;
    end
  end
endmodule

/* File: lcd_bridge_monitor.sv */
`timescale 1ns/10ps
module lcd_bridge_monitor
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic lcd_rs,
  input wire logic lcd_rw,
  input wire logic lcd_en,
  input wire logic [7:0] lcd_d_out,
  input wire logic lcd_d_oe
);
  // Cycles since the last port request; saturates so idle time never wraps
  logic [5:0] age, next_age;
  logic req;
  assign req = (s_axi_awvalid && s_axi_awready &&
    s_axi_awaddr[31:3] == 29'h0200_1000) || (s_axi_arvalid &&
    s_axi_arready && s_axi_araddr[31:3] == 29'h0200_1000);
  always_comb
  begin
    next_age = (age == 6'h3F) ? age : age + 6'h01;
    if (req)
      next_age = 6'h00;
  end
  always_ff @(posedge aclk)
    age <= aresetn ? next_age : 6'h3F;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  resp_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp not held");
  data_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata not held");
  read_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
  write_block_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
  strobe_late_a:
    assert property ($rose(lcd_en) |-> age inside {[3:12]})
      else $error("strobe start out of place");
  strobe_end_a:
    assert property ($fell(lcd_en) |-> age inside {[14:30]})
      else $error("access ended too early or late");
  pulse_len_a:
    assert property ($rose(lcd_en) |-> lcd_en [*8])
      else $error("strobe too short");
  pins_steady_a:
    assert property (lcd_en |-> $stable(lcd_rs) && $stable(lcd_rw) &&
      $stable(lcd_d_out)) else $error("pins moved under strobe");
  drive_dir_a:
    assert property (lcd_en |-> lcd_d_oe == !lcd_rw)
      else $error("data bus driven on read");
  cover property ($rose(lcd_en) && lcd_rw);
  cover property ($rose(lcd_en) && !lcd_rw && lcd_rs);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind char_lcd_access_bridge lcd_bridge_monitor
  u_lcd_bridge_monitor (.*);

/* File: lcd_module_model.sv */
`timescale 1ns/10ps
module lcd_module_model
(
  input wire logic aclk,
  input wire logic lcd_rs,
  input wire logic lcd_rw,
  input wire logic lcd_en,
  input wire logic [7:0] lcd_d_out,
  input wire logic [7:0] rd_byte,
  output logic [7:0] lcd_d_in,
  output logic [7:0] last_wr,
  output logic last_rs
);
  logic en_q = 1'b0;
  initial lcd_d_in = 8'h00;
  always @(posedge aclk)
  begin
    en_q <= lcd_en;
    // Released bus toggles so a stale byte can never pass as a capture
    lcd_d_in <= (lcd_en && lcd_rw) ? rd_byte : ~lcd_d_in;
    // Writes land on the falling strobe
    if (en_q && !lcd_en && !lcd_rw)
    begin
      last_wr <= lcd_d_out;
      last_rs <= lcd_rs;
    end
  end
endmodule

/* File: tb_char_lcd_access_bridge.sv */
`timescale 1ns/10ps
module tb_char_lcd_access_bridge;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, lcd_rs, lcd_rw, lcd_en, lcd_d_oe, last_rs, m;
  logic secondary_irq_input_seven;
  logic [1:0] s_axi_bresp, s_axi_rresp, br, rr;
  logic [7:0] lcd_d_in, lcd_d_out, last_wr, c;
  logic [7:0] rd_byte = 8'h00;
  logic [31:0] rv, seed = 32'h0000_2FC3;
  int n_mismatch = 0;
  int samples_checked = 0;
  char_lcd_access_bridge u_char_lcd_access_bridge (.*);
  lcd_module_model u_lcd_module_model (.*);
  initial
  begin
    forever #12.5 aclk = ~aclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
    end
  endfunction
  // Opcode prefix bit at position k, random operand bits below it
  function automatic logic [7:0] cmd_of(input int k, input logic [7:0] r);
    logic [7:0] p;
    begin
      p = 8'h01 << k;
      return p | (r & (p - 8'h01));
    end
  endfunction
  task automatic summarize();
    begin
      if (n_mismatch == 0 && samples_checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      samples_checked++;
      if (got !== exp)
      begin
        n_mismatch++;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Ready is looked at mid-cycle, so the handshake edge is known in advance
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic ta, tw, t;
    begin
      ta = 1'b0;
      tw = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do
      begin
        @(negedge aclk);
        ta |= s_axi_awready;
        tw |= s_axi_wready;
        @(posedge aclk);
        if (ta)
          s_axi_awvalid <= 1'b0;
        if (tw)
          s_axi_wvalid <= 1'b0;
      end while (!(ta && tw));
      // Late bready lets the response stand a while
      repeat (2) @(posedge aclk);
      s_axi_bready <= 1'b1;
      do
      begin
        @(negedge aclk);
        t = s_axi_bvalid;
        br = s_axi_bresp;
        @(posedge aclk);
      end while (!t);
      s_axi_bready <= 1'b0;
    end
  endtask
  task automatic rd(input logic [31:0] a);
    logic t;
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do
      begin
        @(negedge aclk);
        t = s_axi_arready;
        @(posedge aclk);
      end while (!t);
      s_axi_arvalid <= 1'b0;
      @(posedge aclk);
      s_axi_rready <= 1'b1;
      do
      begin
        @(negedge aclk);
        t = s_axi_rvalid;
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        @(posedge aclk);
      end while (!t);
      s_axi_rready <= 1'b0;
    end
  endtask
  task automatic port(input logic [31:0] a, input logic r, input logic [7:0] d);
    int n;
    begin
      if (r)
      begin
        rd(a);
        chk(rv, 32'h0);
      end
      else
      begin
        wr(a, {24'h0, d});
        chk(br, char_lcd_pkg::RESP_OKAY);
      end
      chk(lcd_en, 1'b0);
      rv = 32'h0;
      for (n = 0; n < 40 && rv[0] !== 1'b1; n++)
        rd(char_lcd_pkg::RAW_FLAG_ADDR);
      chk(rv[0], 1'b1);
      rd(char_lcd_pkg::MASKED_STATUS_ADDR);
      chk(rv[0], m);
      chk(secondary_irq_input_seven, m);
      wr(char_lcd_pkg::RAW_FLAG_ADDR, 32'h0);
      rd(char_lcd_pkg::RAW_FLAG_ADDR);
      chk(rv[0], 1'b0);
    end
  endtask
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(secondary_irq_input_seven, 1'b0);
    m = 1'b1;
    wr(char_lcd_pkg::IRQ_MASK_ADDR, 32'h1);
    for (int k = 0; k < 8; k++)
    begin
      seed = xs(seed);
      c = cmd_of(k, seed[7:0]);
      port(char_lcd_pkg::COMMAND_PORT_ADDR, 1'b0, c);
      chk(last_wr, c);
      chk(last_rs, 1'b0);
    end
    seed = xs(seed);
    port(char_lcd_pkg::DATA_PORT_ADDR, 1'b0, seed[15:8]);
    chk(last_wr, seed[15:8]);
    chk(last_rs, 1'b1);
    for (int i = 0; i < 2; i++)
    begin
      seed = xs(seed);
      rd_byte <= seed[7:0];
      port(i != 0 ? char_lcd_pkg::DATA_PORT_ADDR :
        char_lcd_pkg::COMMAND_PORT_ADDR, 1'b1, 8'h00);
      rd(char_lcd_pkg::CAPTURED_BYTE_ADDR);
      chk(rv[7:0], rd_byte);
    end
    m = 1'b0;
    wr(char_lcd_pkg::IRQ_MASK_ADDR, 32'h0);
    port(char_lcd_pkg::DATA_PORT_ADDR, 1'b0, 8'h5A);
    wr(char_lcd_pkg::BASE_ADDR + 32'h18, 32'h1);
    chk(br, char_lcd_pkg::RESP_SLVERR);
    rd(char_lcd_pkg::BASE_ADDR + 32'h18);
    chk(rr, char_lcd_pkg::RESP_SLVERR);
    summarize();
  end
  initial
  begin
    #500000;
    n_mismatch++;
    summarize();
  end
endmodule
